// ==== arf_pkg.sv ====
`default_nettype none
package arf_pkg;
	// register byte addresses on the bus
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_FORMAT = 4'h4;
	localparam logic [3:0] ADDR_RES_HI = 4'h8;
	localparam logic [3:0] ADDR_RES_LO = 4'hc;
	localparam int ADDR_W = 4;
	// control and format register fields, sizes, reset values and states
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_START_BIT  = 1;
	localparam int CTRL_CHAN_LSB   = 2;
	localparam int CHAN_W          = 5;
	localparam int FORMAT_JUST_BIT = 7;
	localparam int RES_W           = 10;
	localparam int CONV_CYCLES     = 11;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] FORMAT_RESET = 8'h00;
	typedef enum logic [1:0] {
		ARF_IDLE,
		ARF_CONVERT,
		ARF_LOAD
	} arf_state_t;
endpackage : arf_pkg
`default_nettype wire

// ==== arf_result_store.sv ====
`timescale 1ns/1ps
`default_nettype none
// holds the two result bytes; no reset, contents are unknown after power-up
module arf_result_store (
	input  wire logic       mclk,
	input  wire logic       load,
	input  wire logic [9:0] result,
	input  wire logic       justify_right,
	input  wire logic       wr_hi,
	input  wire logic       wr_lo,
	input  wire logic [7:0] wdata,
	output logic      [7:0] high_byte,
	output logic      [7:0] low_byte
);
	logic [7:0] high_d;
	logic [7:0] low_d;

	always_comb begin
		high_d = high_byte;
		low_d  = low_byte;
		if (load) begin
			if (justify_right) begin
				high_d = {6'h00, result[9:8]};
				low_d  = result[7:0];
			end else begin
				high_d = result[9:2];
				low_d  = {result[1:0], 6'h00};
			end
		end else begin
			if (wr_hi)
				high_d = wdata;
			if (wr_lo)
				low_d = wdata;
		end
	end

	// deliberately not reset: device resets leave the results unchanged
	always_ff @(posedge mclk) begin
		high_byte <= high_d;
		low_byte  <= low_d;
	end
endmodule : arf_result_store
`default_nettype wire

// ==== arf_adc_result_formatter.sv ====
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - left justified: result bits 1:0 go to low byte 7:6, rest zero
// - right justified: result bits 9:8 go to high byte 1:0, rest zero
// - right justified: result bits 7:0 fill the low byte
// - result bytes read/write, unknown at power-up, kept over resets
// - each conversion yields a 10-bit result of 1024 steps
// - format bit 1 selects right, 0 selects left justification
// - left justified: result bits 9:2 fill the high byte
// - start flag clears itself at completion; 1 means busy
module arf_adc_result_formatter #(
	parameter int RESULT_W = 10
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [3:0] avs_address,
	input  wire logic       avs_read,
	input  wire logic       avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0] avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic            avs_waitrequest,
	input  wire logic [9:0] sample_code,
	output logic      [4:0] channel_select,
	output logic            converter_enable,
	output logic            conversion_busy
);
	// refuse sizes that the datapath and the cycle counter cannot carry
	if (RESULT_W != arf_pkg::RES_W) begin : g_bad_result_w
		$error("RESULT_W must equal the converter width");
	end
	if (arf_pkg::CONV_CYCLES < 2 || arf_pkg::CONV_CYCLES > 16) begin : g_bad_conv
		$error("conversion length must fit the cycle counter");
	end
	if (arf_pkg::ADDR_W != 4) begin : g_bad_addr_w
		$error("address decode assumes a four bit byte address");
	end

	arf_pkg::arf_state_t state_q;
	arf_pkg::arf_state_t state_d;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	logic [7:0]  ctrl_q;
	logic [7:0]  ctrl_d;
	logic [7:0]  format_q;
	logic [7:0]  format_d;
	logic [9:0]  sample_q;
	logic [9:0]  sample_d;
	logic        ack_q;
	logic        ack_d;
	logic [31:0] rdata_d;
	logic        load;
	logic        wr_hi;
	logic        wr_lo;
	logic        access;
	logic        wr_go;
	logic [7:0]  high_byte;
	logic [7:0]  low_byte;
	logic [4:0]  chan_d;
	logic        enable_d;
	logic        busy_d;
	logic        waitreq_d;

	// true when the bus address selects the given register
	function automatic logic addr_hit(
		input logic [3:0] addr,
		input logic [3:0] target
	);
		return addr == target;
	endfunction : addr_hit

	// readback word for one register byte, upper bits read as zero
	function automatic logic [31:0] pad_byte(input logic [7:0] val);
		return {24'h000000, val};
	endfunction : pad_byte

	// one wait state: waitrequest drops in the cycle after a request arrives
	assign access = (avs_read | avs_write) & ~ack_q;
	assign wr_go  = avs_write & ack_q & avs_byteenable[0];
	assign wr_hi  = wr_go && addr_hit(avs_address, arf_pkg::ADDR_RES_HI);
	assign wr_lo  = wr_go && addr_hit(avs_address, arf_pkg::ADDR_RES_LO);
	assign load   = (state_q == arf_pkg::ARF_LOAD);

	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		ctrl_d   = ctrl_q;
		format_d = format_q;
		sample_d = sample_q;
		ack_d    = access;
		if (wr_go && addr_hit(avs_address, arf_pkg::ADDR_CTRL))
			ctrl_d = {1'b0, avs_writedata[6:0]};
		if (wr_go && addr_hit(avs_address, arf_pkg::ADDR_FORMAT))
			format_d = {avs_writedata[7], 7'h00};
		case (state_q)
			arf_pkg::ARF_IDLE: begin
				// start is only honoured with the converter enabled;
				// acquisition timing is left to software
				if (ctrl_q[arf_pkg::CTRL_START_BIT]) begin
					if (ctrl_q[arf_pkg::CTRL_ENABLE_BIT]) begin
						state_d = arf_pkg::ARF_CONVERT;
						cnt_d   = 4'h0;
					end else begin
						ctrl_d[arf_pkg::CTRL_START_BIT] = 1'b0;
					end
				end
			end
			arf_pkg::ARF_CONVERT: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == 4'(arf_pkg::CONV_CYCLES - 1)) begin
					sample_d = sample_code;
					state_d  = arf_pkg::ARF_LOAD;
				end
				if (!ctrl_q[arf_pkg::CTRL_ENABLE_BIT]) begin
					state_d = arf_pkg::ARF_IDLE;
					ctrl_d[arf_pkg::CTRL_START_BIT] = 1'b0;
				end
			end
			arf_pkg::ARF_LOAD: begin
				state_d = arf_pkg::ARF_IDLE;
				// hardware clear wins over any software write this cycle
				ctrl_d[arf_pkg::CTRL_START_BIT] = 1'b0;
			end
			default: state_d = arf_pkg::ARF_IDLE;
		endcase
	end

	always_comb begin
		// read data stand until the next read is answered
		rdata_d = avs_readdata;
		if (avs_read && !ack_q) begin
			case (avs_address)
				arf_pkg::ADDR_CTRL:   rdata_d = pad_byte(ctrl_d);
				arf_pkg::ADDR_FORMAT: rdata_d = pad_byte(format_q);
				arf_pkg::ADDR_RES_HI: rdata_d = pad_byte(high_byte);
				arf_pkg::ADDR_RES_LO: rdata_d = pad_byte(low_byte);
				default:              rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q  <= arf_pkg::ARF_IDLE;
			cnt_q    <= 4'h0;
			ctrl_q   <= arf_pkg::CTRL_RESET;
			format_q <= arf_pkg::FORMAT_RESET;
			sample_q <= 10'h000;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			ctrl_q   <= ctrl_d;
			format_q <= format_d;
			sample_q <= sample_d;
		end
	end

	// bus answer: one wait state, read data held between reads
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_q        <= ack_d;
			avs_readdata <= rdata_d;
		end
	end

	// outputs follow the next control value so they move with the write
	always_comb begin
		chan_d    = ctrl_d[arf_pkg::CTRL_CHAN_LSB +: arf_pkg::CHAN_W];
		enable_d  = ctrl_d[arf_pkg::CTRL_ENABLE_BIT];
		busy_d    = ctrl_d[arf_pkg::CTRL_START_BIT];
		waitreq_d = ~access;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			avs_waitrequest  <= 1'b1;
			channel_select   <= 5'h00;
			converter_enable <= 1'b0;
			conversion_busy  <= 1'b0;
		end else begin
			avs_waitrequest  <= waitreq_d;
			channel_select   <= chan_d;
			converter_enable <= enable_d;
			conversion_busy  <= busy_d;
		end
	end

	// results take the sample only in the single load cycle after conversion; bus writes to ADDR_RES_HI and ADDR_RES_LO change them otherwise
	arf_result_store u_store (
		.mclk          (mclk),
		.load          (load),
		.result        (sample_q),
		.justify_right (format_q[arf_pkg::FORMAT_JUST_BIT]),
		.wr_hi         (wr_hi),
		.wr_lo         (wr_lo),
		.wdata         (avs_writedata[7:0]),
		.high_byte     (high_byte),
		.low_byte      (low_byte)
	);
endmodule : arf_adc_result_formatter
`default_nettype wire

// ==== arf_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module arf_asserts (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [4:0]  channel_select,
	input wire logic        converter_enable,
	input wire logic        conversion_busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence ctrl_wr;
		avs_write && !avs_waitrequest && avs_byteenable[0] &&
			avs_address == arf_pkg::ADDR_CTRL;
	endsequence
	AST_ONE_WAIT: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
	AST_ONE_CYCLE: assert property (
		!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
	AST_RD_HOLD: assert property (
		!avs_read |-> $stable(avs_readdata)) else $error("read data moved");
	AST_CHAN: assert property (
		ctrl_wr |=> channel_select == $past(avs_writedata[6:2])) else $error("channel");
	AST_EN: assert property (
		ctrl_wr |=> converter_enable == $past(avs_writedata[0])) else $error("enable");
	AST_START: assert property (
		ctrl_wr ##0 (avs_writedata[1:0] == 2'h3 && !conversion_busy)
		|=> conversion_busy) else $error("start lost");
	AST_BUSY_MIN: assert property (
		$rose(conversion_busy) |-> conversion_busy[*8]) else $error("busy short");
	AST_BUSY_END: assert property (
		$rose(conversion_busy) |-> ##[8:16] !conversion_busy) else $error("busy stuck");
endmodule : arf_asserts
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [9:0]  sample_code = 10'h0;
	logic [4:0]  channel_select;
	logic        converter_enable;
	logic        conversion_busy;
	logic [7:0]  rd;
	int          error_cnt = 0;
	int          total_checks = 0;
	arf_adc_result_formatter arf_adc_result_formatter_inst (.*);
	initial forever #25 mclk = ~mclk;
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (e !== g) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// an edge passes first so back-to-back calls never drive twice at once
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			summarize();
		end
	endtask : bus
	task automatic conv(input logic [7:0] fmt, input logic [9:0] code,
			input logic [7:0] old_hi, input logic [7:0] hi, input logic [7:0] lo);
		int n;
		n = 0;
		sample_code <= code;
		bus(1'b1, arf_pkg::ADDR_FORMAT, fmt);
		bus(1'b1, arf_pkg::ADDR_CTRL, 8'h15);
		repeat (8) @(posedge mclk);
		bus(1'b1, arf_pkg::ADDR_CTRL, 8'h17);
		bus(1'b0, arf_pkg::ADDR_RES_HI, 8'h00);
		chk("high while busy", old_hi, rd);
		while (conversion_busy !== 1'b0 && n < 40) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 40) begin
			error_cnt++;
			summarize();
		end
		bus(1'b0, arf_pkg::ADDR_RES_HI, 8'h00);
		chk("high byte", hi, rd);
		bus(1'b0, arf_pkg::ADDR_RES_LO, 8'h00);
		chk("low byte", lo, rd);
		$display("conversion test done");
	endtask : conv
	task automatic refused;
		avs_byteenable <= 4'he;
		bus(1'b1, arf_pkg::ADDR_RES_LO, 8'h11);
		avs_byteenable <= 4'hf;
		bus(1'b0, arf_pkg::ADDR_RES_LO, 8'h00);
		chk("masked write", 8'h40, rd);
		bus(1'b1, arf_pkg::ADDR_CTRL, 8'h95);
		bus(1'b0, arf_pkg::ADDR_CTRL, 8'h00);
		chk("control readback", 8'h15, rd);
		$display("refusal test done");
	endtask : refused
	task automatic abort;
		sample_code <= 10'h155;
		bus(1'b1, arf_pkg::ADDR_CTRL, 8'h17);
		repeat (6) @(posedge mclk);
		bus(1'b1, arf_pkg::ADDR_CTRL, 8'h14);
		repeat (16) @(posedge mclk);
		chk("busy after abort", 8'h00, {7'h00, conversion_busy});
		bus(1'b0, arf_pkg::ADDR_RES_LO, 8'h00);
		chk("low after abort", 8'hca, rd);
		$display("abort test done");
	endtask : abort
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		bus(1'b1, arf_pkg::ADDR_RES_HI, 8'ha5);
		bus(1'b1, arf_pkg::ADDR_RES_LO, 8'h5a);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		bus(1'b0, arf_pkg::ADDR_RES_HI, 8'h00);
		chk("high kept", 8'ha5, rd);
		bus(1'b0, arf_pkg::ADDR_RES_LO, 8'h00);
		chk("low kept", 8'h5a, rd);
		bus(1'b0, 4'h2, 8'h00);
		chk("unmapped", 8'h00, rd);
		$display("register test done");
		conv(8'h00, 10'h2b5, 8'ha5, 8'had, 8'h40);
		refused();
		conv(8'h80, 10'h3ca, 8'had, 8'h03, 8'hca);
		abort();
		summarize();
	end
endmodule : tb
bind arf_adc_result_formatter arf_asserts arf_asserts_inst (.*);
`default_nettype wire
